// >>> src/swbus_pkg.sv
// Constants for the single-wire bus transceiver control logic.
// Assumes a 100 MHz core clock; all pin timings are derived from it here.
package swbus_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned CYC_PER_US     = CLK_HZ / 1_000_000;
  localparam int unsigned CYC_PER_MS     = CLK_HZ / 1_000;

  ////////////////////////////////////////////////////////////////////////////
  // Timing, in the printed units
  localparam int unsigned TX_TIMEOUT_MS  = 17;
  localparam int unsigned WAKE_FILT_US   = 10;
  localparam int unsigned STANDBY_MS     = 250;

  // Cycle counts; filter is a least time, so it rounds up
  localparam int unsigned TX_TIMEOUT_CYC = TX_TIMEOUT_MS * CYC_PER_MS;
  localparam int unsigned WAKE_FILT_CYC  = (WAKE_FILT_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int unsigned STANDBY_CYC    = STANDBY_MS * CYC_PER_MS;

  ////////////////////////////////////////////////////////////////////////////
  // Mode pin code {mode_sel_b, mode_sel_a}
  localparam logic [1:0]  MODE_SLEEP     = 2'h0;
  localparam logic [1:0]  MODE_HIGHSPEED = 2'h1;
  localparam logic [1:0]  MODE_WAKEUP    = 2'h2;
  localparam logic [1:0]  MODE_NORMAL    = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Synchroniser bit positions
  localparam int unsigned SY_TX          = 0;
  localparam int unsigned SY_MA          = 1;
  localparam int unsigned SY_MB          = 2;
  localparam int unsigned SY_DOM         = 3;
  localparam int unsigned SY_HV          = 4;
  localparam int unsigned SY_LGND        = 5;
  localparam int unsigned SY_UVLO        = 6;
  localparam int unsigned SY_LOWSUP      = 7;
  localparam int unsigned SY_OTEMP       = 8;
  localparam int unsigned SY_N           = 9;
  localparam logic [SY_N-1:0] SY_RESET   = 9'h001;

  ////////////////////////////////////////////////////////////////////////////
  // Receive event stream
  localparam int unsigned EVT_W          = 3;
  localparam int unsigned EVT_DEPTH      = 32;

  typedef enum logic [1:0] {ST_SLEEP, ST_STANDBY, ST_ACTIVE} link_state_t;

endpackage

// >>> src/single_wire_bus_transceiver_control.sv
// Control logic of a single-wire bus transceiver, plus its receive event FIFO.
// Pins arrive asynchronously; the analog driver/receiver sits outside and is
// steered by the enables and level selects below.
//
// Functional notes
// - Transmit high or undriven leaves the bus recessive, driver off.
// - Transmit low drives dominant, normal or raised level per mode.
// - Sleep mode never drives the bus dominant.
// - Undriven transmit input reads as high.
// - Dominant transmit beyond the timeout switches the bus driver off.
// - Next transmit low-to-high re-enables transmission at once.
// - Undriven mode inputs read low, selecting sleep.
// - Mode code: 00 sleep, a=1 high-speed, b=1 raised wake-up, 11 normal.
// - Sleep left on valid raised-level wake or non-zero mode code.
// - High-speed mode disables transmit wave shaping.
// - Wake-up mode sends dominant bits at the raised level.
// - Normal mode transmits with wave shaping enabled.
// - Receive output high when bus recessive, low when dominant.
// - Receive output undriven in sleep until wake or mode change.
// - Bus wake-up pulls the receive output low as interrupt.
// - Without a mode change after bus wake, return to sleep after 250 ms.
// - All non-sleep modes forward the bus state to the receive output.
// - Load ground path stays connected unless loss of ground.
// - Transmission continues on loss of ground until undervoltage lockout.
// - Low supply makes wake-up mode use the normal dominant level.
// - Overtemperature disables the high-side driver.
// - Transmit timeout is 17 ms in all active modes.
// - Raised level counts as wake only after the filter delay.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Flip-flop FIFO, valid/ready on both sides
module event_fifo #(
  parameter int unsigned WIDTH = 3,
  parameter int unsigned DEPTH = 32
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  wire              push;
  wire              pop;
  wire              full;
  wire              empty;
  wire [AW-1:0]     wr_ptr_nxt;
  wire [AW-1:0]     rd_ptr_nxt;
  wire [AW:0]       count_nxt;

  // Count is one bit wider than the pointers, so full and empty never alias
  assign full       = (count_r == (AW+1)'(DEPTH));
  assign empty      = (count_r == '0);
  assign push       = in_valid && !full;
  assign pop        = out_ready && !empty;
  assign in_ready   = !full;
  assign out_valid  = !empty;
  assign out_data   = mem_r[rd_ptr_r];
  // Wrap by compare, so a depth that is not a power of two still works
  assign wr_ptr_nxt = (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + AW'(1);
  assign rd_ptr_nxt = (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + AW'(1);
  assign count_nxt  = count_r + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_nxt;
      if (pop)  rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_nxt;
    end
  end

  // Storage needs no reset; only written entries are ever read
  always_ff @(posedge core_clk) begin
    if (push) mem_r[wr_ptr_r] <= in_data;
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Transceiver control top
module single_wire_bus_transceiver_control
  import swbus_pkg::*;
#(
  parameter int unsigned TX_TIMEOUT_CYCLES = swbus_pkg::TX_TIMEOUT_CYC,
  parameter int unsigned STANDBY_CYCLES    = swbus_pkg::STANDBY_CYC,
  parameter int unsigned WAKE_FILT_CYCLES  = swbus_pkg::WAKE_FILT_CYC,
  parameter int unsigned FIFO_DEPTH        = swbus_pkg::EVT_DEPTH
) (
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  // Host pins
  input  wire logic                       tx_pin,
  input  wire logic                       tx_pin_driven,
  input  wire logic                       mode_sel_a,
  input  wire logic                       mode_sel_a_driven,
  input  wire logic                       mode_sel_b,
  input  wire logic                       mode_sel_b_driven,
  output logic                            rx_out,
  output logic                            rx_oe_n,
  // Bus line sensing and drive
  input  wire logic                       bus_line_dom,
  input  wire logic                       raised_level_wake,
  output logic                            bus_line_oe_n,
  output logic                            bus_line_raised,
  output logic                            wave_shape_en,
  output logic                            load_gnd_open,
  // Supply and fault indications
  input  wire logic                       loss_of_ground,
  input  wire logic                       supply_uvlo,
  input  wire logic                       supply_low,
  input  wire logic                       over_temp,
  // Status
  output logic                            low_power,
  output logic                            tx_timed_out,
  output logic [1:0]                      mode_now,
  // Receive event stream {mode, level}
  output logic                            evt_valid,
  input  wire logic                       evt_ready,
  output logic [swbus_pkg::EVT_W-1:0]     evt_data
);
  import swbus_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Input conditioning
  wire [SY_N-1:0] raw_in;
  // Driven flags stand in for the pin pull-up and pull-downs
  assign raw_in[SY_TX]     = tx_pin_driven ? tx_pin : 1'b1;
  assign raw_in[SY_MA]     = mode_sel_a_driven ? mode_sel_a : 1'b0;
  assign raw_in[SY_MB]     = mode_sel_b_driven ? mode_sel_b : 1'b0;
  assign raw_in[SY_DOM]    = bus_line_dom;
  assign raw_in[SY_HV]     = raised_level_wake;
  assign raw_in[SY_LGND]   = loss_of_ground;
  assign raw_in[SY_UVLO]   = supply_uvlo;
  assign raw_in[SY_LOWSUP] = supply_low;
  assign raw_in[SY_OTEMP]  = over_temp;

  logic [SY_N-1:0] s1_r;
  logic [SY_N-1:0] s2_r;
  logic [SY_N-1:0] s3_r;
  logic [SY_N-1:0] in_r;

  // Three stages; a level counts once stages two and three agree
  // Reset values equal the idle pin levels, so no false edge follows reset
  genvar gi;
  generate
    for (gi = 0; gi < SY_N; gi++) begin : g_sync
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_r[gi] <= SY_RESET[gi];
          s2_r[gi] <= SY_RESET[gi];
          s3_r[gi] <= SY_RESET[gi];
          in_r[gi] <= SY_RESET[gi];
        end else begin
          s1_r[gi] <= raw_in[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          if (s2_r[gi] == s3_r[gi]) in_r[gi] <= s3_r[gi];
        end
      end
    end
  endgenerate

  wire       tx_high  = in_r[SY_TX];
  wire       bus_dom  = in_r[SY_DOM];
  wire       hv_seen  = in_r[SY_HV];
  wire       uvlo     = in_r[SY_UVLO];
  wire       low_sup  = in_r[SY_LOWSUP];
  wire       otemp    = in_r[SY_OTEMP];
  wire [1:0] mode_pin = {in_r[SY_MB], in_r[SY_MA]};
  wire       mode_off = (mode_pin == MODE_SLEEP);

  ////////////////////////////////////////////////////////////////////////////
  // Wake filter and mode state
  link_state_t state_r;
  link_state_t state_nxt;
  logic [31:0] wake_cnt_r;
  logic [31:0] sby_cnt_r;

  // Raised level must persist the full filter time
  wire wake_valid = hv_seen && (wake_cnt_r >= WAKE_FILT_CYCLES - 1);
  wire sby_expire = (sby_cnt_r >= STANDBY_CYCLES - 1);
  wire [31:0] wake_cnt_nxt;
  wire [31:0] sby_cnt_nxt;

  // Any drop of the raised level restarts the filter from zero
  assign wake_cnt_nxt = (hv_seen && state_r == ST_SLEEP && !wake_valid) ? wake_cnt_r + 32'h1 : '0;
  // Standby timer clears to zero one cycle after the state leaves standby
  assign sby_cnt_nxt  = (state_r == ST_STANDBY) ? sby_cnt_r + 32'h1 : '0;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_SLEEP: begin
        if (!mode_off) state_nxt = ST_ACTIVE;
        else if (wake_valid) state_nxt = ST_STANDBY;
      end
      ST_STANDBY: begin
        if (!mode_off) state_nxt = ST_ACTIVE;
        else if (sby_expire) state_nxt = ST_SLEEP;
      end
      ST_ACTIVE: begin
        if (mode_off) state_nxt = ST_SLEEP;
      end
      // Unused code: fall back to sleep, where nothing is driven
      default: begin
        state_nxt = ST_SLEEP;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= ST_SLEEP;
      wake_cnt_r <= '0;
      sby_cnt_r  <= '0;
    end else begin
      state_r    <= state_nxt;
      wake_cnt_r <= wake_cnt_nxt;
      sby_cnt_r  <= sby_cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit path and stuck-dominant timeout
  logic        txto_r;
  logic [31:0] dom_cnt_r;
  logic        tx_high_d_r;

  wire active  = (state_r == ST_ACTIVE) && !mode_off;
  // Rise is taken from the filtered level, so a glitch cannot clear a timeout
  wire tx_rise = tx_high && !tx_high_d_r;
  // Loss of ground alone does not stop the driver; lockout or overtemperature does
  wire drive   = active && !tx_high && !txto_r && !otemp && !uvlo;
  // Faults pause the drive but not the count, so a stuck input still times out
  wire        dom_run;
  wire [31:0] dom_cnt_nxt;
  wire        txto_hit;

  assign dom_run     = active && !tx_high && !txto_r;
  assign dom_cnt_nxt = dom_run ? dom_cnt_r + 32'h1 : '0;
  assign txto_hit    = (dom_cnt_r >= TX_TIMEOUT_CYCLES - 1);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      txto_r      <= 1'b0;
      dom_cnt_r   <= '0;
      tx_high_d_r <= 1'b1;
    end else begin
      tx_high_d_r <= tx_high;
      dom_cnt_r   <= dom_cnt_nxt;
      if (tx_rise) txto_r <= 1'b0;
      else if (txto_hit) txto_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive event stream; an edge waits while the FIFO is full
  logic       bus_dom_d_r;
  logic       evt_pend_r;
  logic [EVT_W-1:0] evt_word_r;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic [EVT_W-1:0] fifo_out_data;

  wire bus_edge   = active && (bus_dom != bus_dom_d_r);
  wire evt_pushed = evt_pend_r && fifo_in_ready;
  // Output stage reloads when empty or when its word is taken
  wire out_take   = !evt_valid || evt_ready;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_dom_d_r <= 1'b0;
      evt_pend_r  <= 1'b0;
      evt_word_r  <= '0;
    end else begin
      bus_dom_d_r <= bus_dom;
      // Newest edge overwrites a stalled one; the latest bus level wins
      if (bus_edge) begin
        evt_pend_r <= 1'b1;
        evt_word_r <= {mode_pin, !bus_dom};
      end else if (evt_pushed) begin
        evt_pend_r <= 1'b0;
      end
    end
  end

  event_fifo #(
    .WIDTH (EVT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (evt_pend_r),
    .in_ready  (fifo_in_ready),
    .in_data   (evt_word_r),
    .out_valid (fifo_out_valid),
    .out_ready (out_take),
    .out_data  (fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output registers
  wire rx_level = (state_r == ST_STANDBY) ? 1'b0 : !bus_dom;
  wire rx_off   = (state_r == ST_SLEEP);
  wire raised   = (mode_pin == MODE_WAKEUP) && !low_sup;

  // Receive pin; sleep releases it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_out  <= 1'b1;
      rx_oe_n <= 1'b1;
    end else begin
      rx_out  <= rx_off ? 1'b1 : rx_level;
      rx_oe_n <= rx_off;
    end
  end

  // Bus driver steering
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_line_oe_n   <= 1'b1;
      bus_line_raised <= 1'b0;
      wave_shape_en   <= 1'b1;
      load_gnd_open   <= 1'b0;
    end else begin
      bus_line_oe_n   <= !drive;
      bus_line_raised <= drive && raised;
      wave_shape_en   <= (mode_pin != MODE_HIGHSPEED);
      load_gnd_open   <= in_r[SY_LGND];
    end
  end

  // Status
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_power    <= 1'b1;
      tx_timed_out <= 1'b0;
      mode_now     <= MODE_SLEEP;
    end else begin
      low_power    <= rx_off;
      tx_timed_out <= txto_r;
      mode_now     <= mode_pin;
    end
  end

  // Event stream output stage
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_valid <= 1'b0;
      evt_data  <= '0;
    end else if (out_take) begin
      evt_valid <= fifo_out_valid;
      evt_data  <= fifo_out_data;
    end
  end

endmodule

// >>> verif/swbus_ctl_sva.sv
// Port assertions for the transceiver control top.
// Bound below; sees the top's ports and timeout parameter only.
`timescale 1ns/1ps
module swbus_ctl_sva
  import swbus_pkg::*;
#(
  parameter int unsigned TX_TIMEOUT_CYCLES = 200
) (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst_n,
  // Inputs seen
  input wire logic       bus_line_dom,
  input wire logic       loss_of_ground,
  input wire logic       supply_uvlo,
  input wire logic       supply_low,
  input wire logic       over_temp,
  // Outputs checked
  input wire logic       rx_out,
  input wire logic       rx_oe_n,
  input wire logic       bus_line_oe_n,
  input wire logic       bus_line_raised,
  input wire logic       wave_shape_en,
  input wire logic       load_gnd_open,
  input wire logic       low_power,
  input wire logic       tx_timed_out,
  input wire logic [1:0] mode_now
);
  import swbus_pkg::*;
  // Length of the current dominant drive
  logic [31:0] drv_cnt_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) drv_cnt_r <= 32'h0;
    else drv_cnt_r <= bus_line_oe_n ? 32'h0 : drv_cnt_r + 32'h1;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // Previous-cycle guards absorb one cycle of output lag
  a_sleep_no_drv: assert property (low_power && $past(low_power) |-> bus_line_oe_n)
    else $error("bus driven in sleep");
  a_sleep_rx_off: assert property (low_power && $past(low_power) |-> rx_oe_n)
    else $error("rx driven in sleep");
  a_raised_with_drv: assert property (bus_line_raised |-> !bus_line_oe_n)
    else $error("raised level without drive");
  a_shape_by_mode: assert property ($stable(mode_now) && mode_now == $past(mode_now, 2) |->
    wave_shape_en == (mode_now != MODE_HIGHSPEED)) else $error("wave shaping wrong for mode");
  a_timeout_off: assert property (tx_timed_out && $past(tx_timed_out) |-> bus_line_oe_n)
    else $error("driving while timed out");
  a_timeout_len: assert property (drv_cnt_r <= TX_TIMEOUT_CYCLES + 4)
    else $error("dominant drive too long");
  a_gnd_open: assert property (loss_of_ground [*8] |-> load_gnd_open)
    else $error("load path not opened");
  a_gnd_closed: assert property (!loss_of_ground [*8] |-> !load_gnd_open)
    else $error("load path opened");
  a_uvlo_off: assert property (supply_uvlo [*8] |-> bus_line_oe_n)
    else $error("driving in undervoltage");
  a_otemp_off: assert property (over_temp [*8] |-> bus_line_oe_n)
    else $error("driving in overtemperature");
  a_lowsup_level: assert property (supply_low [*8] |-> !bus_line_raised)
    else $error("raised level on low supply");
  a_rx_follow: assert property (($stable(bus_line_dom) && mode_now != MODE_SLEEP) [*8] |->
    rx_out == !bus_line_dom && !rx_oe_n) else $error("rx does not follow bus");
  a_wake_irq: assert property ($fell(low_power) && mode_now == MODE_SLEEP |-> ##[0:1]
    (!rx_out && !rx_oe_n)) else $error("no wake interrupt");
  c_timeout: cover property ($rose(tx_timed_out));
  c_bus_wake: cover property ($fell(low_power) && mode_now == MODE_SLEEP);
  c_raised: cover property (bus_line_raised);
endmodule

bind single_wire_bus_transceiver_control swbus_ctl_sva #(.TX_TIMEOUT_CYCLES(TX_TIMEOUT_CYCLES)) u_swbus_ctl_sva (
  .core_clk(core_clk), .rst_n(rst_n), .bus_line_dom(bus_line_dom), .loss_of_ground(loss_of_ground),
  .supply_uvlo(supply_uvlo), .supply_low(supply_low), .over_temp(over_temp), .rx_out(rx_out),
  .rx_oe_n(rx_oe_n), .bus_line_oe_n(bus_line_oe_n), .bus_line_raised(bus_line_raised),
  .wave_shape_en(wave_shape_en), .load_gnd_open(load_gnd_open), .low_power(low_power),
  .tx_timed_out(tx_timed_out), .mode_now(mode_now));

// >>> verif/host_model.sv
// Host-side consumer of the receive event stream.
// Shares the design clock; stall holds acceptance off.
`timescale 1ns/1ps
module host_model (
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  // Event stream
  input  wire logic                       evt_valid,
  output logic                            evt_ready,
  input  wire logic [swbus_pkg::EVT_W-1:0] evt_data,
  // Control and log
  input  wire logic                       stall,
  output logic [7:0]                      got_cnt,
  output logic [swbus_pkg::EVT_W-1:0]     got_last
);
  import swbus_pkg::*;
  // Ready moves only just after an edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_ready <= 1'h0;
      got_cnt <= 8'h0;
      got_last <= '0;
    end else begin
      evt_ready <= !stall;
      if (evt_valid && evt_ready) begin
        got_cnt <= got_cnt + 8'h1;
        got_last <= evt_data;
      end
    end
  end
endmodule

// >>> verif/tb.sv
// Self-checking bench for the transceiver control top.
// Timeouts shortened by parameter; host_model drains events.
`timescale 1ns/1ps
module tb;
  import swbus_pkg::*;
  localparam int unsigned TXTO = 200;
  localparam int unsigned STBY = 300;
  localparam int unsigned WFLT = 20;
  // {ma,mb,mdrv,tx,tdrv,lows,mode[1:0],sleep,oe_n,raised,shape}
  typedef logic [11:0] row_t;
  row_t rows [8] = '{12'hEB1, 12'hFB5, 12'hE35, 12'hA90, 12'h6A3, 12'h6E1, 12'h28D, 12'hC8D};
  logic       core_clk = 1'h0, rst_n = 1'h0, tx_pin = 1'h1, tx_drv = 1'h1;
  logic       ma = 1'h0, mb = 1'h0, mdrv = 1'h1, dom = 1'h0, hvw = 1'h0, stall = 1'h0;
  logic       lgnd = 1'h0, uvlo = 1'h0, lows = 1'h0, otemp = 1'h0;
  logic       rx_out, rx_oe_n, oe_n, raised, shape, gopen, lp, tout, evt_valid, evt_ready;
  logic [1:0] mode_now;
  logic [2:0] evt_data, got_last;
  logic [7:0] got_cnt, base;
  int         mismatches = 0, num_checks = 0, n;
  always #5 core_clk = ~core_clk;
  single_wire_bus_transceiver_control #(.TX_TIMEOUT_CYCLES(TXTO), .STANDBY_CYCLES(STBY),
    .WAKE_FILT_CYCLES(WFLT)) u_single_wire_bus_transceiver_control (
    .core_clk(core_clk), .rst_n(rst_n), .tx_pin(tx_pin), .tx_pin_driven(tx_drv), .mode_sel_a(ma),
    .mode_sel_a_driven(mdrv), .mode_sel_b(mb), .mode_sel_b_driven(mdrv), .rx_out(rx_out),
    .rx_oe_n(rx_oe_n), .bus_line_dom(dom), .raised_level_wake(hvw), .bus_line_oe_n(oe_n),
    .bus_line_raised(raised), .wave_shape_en(shape), .load_gnd_open(gopen), .loss_of_ground(lgnd),
    .supply_uvlo(uvlo), .supply_low(lows), .over_temp(otemp), .low_power(lp), .tx_timed_out(tout),
    .mode_now(mode_now), .evt_valid(evt_valid), .evt_ready(evt_ready), .evt_data(evt_data));
  host_model u_host_model (.core_clk(core_clk), .rst_n(rst_n), .evt_valid(evt_valid),
    .evt_ready(evt_ready), .evt_data(evt_data), .stall(stall), .got_cnt(got_cnt), .got_last(got_last));
  ////////////////////////////////////////
  task automatic chk_bit(string nm, logic exp, logic got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic chk_vec(string nm, logic [7:0] exp, logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic step(int k);
    repeat (k) @(negedge core_clk);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function automatic logic pick(int w);
    return (w == 0) ? tout : (w == 1) ? lp : evt_valid;
  endfunction
  // Bounded wait; running out ends the run
  task automatic wait_sig(int w, logic v, int lim, output int k);
    k = 0;
    while (pick(w) !== v && k < lim) begin
      step(1);
      k++;
    end
    if (k >= lim) begin
      mismatches++;
      $display("[ERR] wait %0d expected %b seen %b", w, v, pick(w));
      results();
    end
  endtask
  initial begin
    step(8);
    rst_n = 1'h1;
    step(2);
    // Normal, recessive, floating tx, high-speed, wake-up, low supply, sleep, floating modes
    foreach (rows[i]) begin
      {ma, mb, mdrv, tx_pin, tx_drv, lows} = rows[i][11:6];
      step(12);
      chk_vec("mode_now", {6'h0, rows[i][5:4]}, {6'h0, mode_now});
      chk_bit("low_power", rows[i][3], lp);
      chk_bit("rx_oe_n", rows[i][3], rx_oe_n);
      chk_bit("bus_oe_n", rows[i][2], oe_n);
      chk_bit("raised", rows[i][1], raised);
      chk_bit("shape", rows[i][0], shape);
    end
    {ma, mb, mdrv, tx_pin, tx_drv, lows} = 6'h3E;
    step(12);
    tx_pin = 1'h0;
    wait_sig(0, 1'h1, TXTO + 40, n);
    chk_bit("timeout_time", 1'(n >= TXTO && n <= TXTO + 10), 1'h1);
    step(2);
    chk_bit("bus_oe_n", 1'h1, oe_n);
    tx_pin = 1'h1;
    step(6);
    chk_bit("tx_timed_out", 1'h0, tout);
    tx_pin = 1'h0;
    step(7);
    chk_bit("bus_oe_n", 1'h0, oe_n);
    otemp = 1'h1;
    step(10);
    chk_bit("bus_oe_n", 1'h1, oe_n);
    otemp = 1'h0;
    lgnd = 1'h1;
    step(10);
    chk_bit("load_gnd_open", 1'h1, gopen);
    chk_bit("bus_oe_n", 1'h0, oe_n);
    uvlo = 1'h1;
    step(10);
    chk_bit("bus_oe_n", 1'h1, oe_n);
    {lgnd, uvlo, tx_pin} = 3'h1;
    dom = 1'h1;
    step(20);
    chk_bit("rx_out", 1'h0, rx_out);
    // Host stalled: output stage, full FIFO and the newest pending word are kept
    base = got_cnt;
    stall = 1'h1;
    repeat (40) begin
      dom = !dom;
      step(8);
    end
    chk_bit("evt_valid", 1'h1, evt_valid);
    chk_vec("words", base, got_cnt);
    stall = 1'h0;
    wait_sig(2, 1'h0, 300, n);
    step(4);
    chk_vec("words", 8'(base + 8'(EVT_DEPTH) + 8'd2), got_cnt);
    chk_vec("last_word", 8'h6, {5'h0, got_last});
    {ma, mb} = 2'h0;
    step(12);
    chk_bit("rx_oe_n", 1'h1, rx_oe_n);
    hvw = 1'h1;
    step(WFLT / 2);
    hvw = 1'h0;
    step(10);
    chk_bit("low_power", 1'h1, lp);
    hvw = 1'h1;
    wait_sig(1, 1'h0, WFLT + 20, n);
    chk_bit("wake_filter", 1'(n >= WFLT), 1'h1);
    step(1);
    chk_bit("rx_out", 1'h0, rx_out);
    chk_bit("rx_oe_n", 1'h0, rx_oe_n);
    hvw = 1'h0;
    wait_sig(1, 1'h1, STBY + 40, n);
    chk_bit("standby_time", 1'(n + 10 >= STBY && n <= STBY + 10), 1'h1);
    step(2);
    chk_bit("rx_oe_n", 1'h1, rx_oe_n);
    hvw = 1'h1;
    wait_sig(1, 1'h0, WFLT + 20, n);
    hvw = 1'h0;
    {ma, mb} = 2'h3;
    step(STBY + 20);
    chk_bit("low_power", 1'h0, lp);
    rst_n = 1'h0;
    step(2);
    chk_vec("reset_outs", 8'hE8, {lp, rx_oe_n, oe_n, raised, shape, gopen, tout, evt_valid});
    rst_n = 1'h1;
    step(8);
    results();
  end
endmodule
